// file: dps_defines.svh
// Purpose: Constants for the dual synthesizer serial program port
// Assumes: Word layout bit positions are shared with the controller
// Notes:   Positions of control bits are design choices
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
`define DPS_WORD_W 23
`define DPS_CTL_LSB 0
`define DPS_CTL_MSB 1
`define DPS_CTL_IF_REF 2'h0
`define DPS_CTL_IF_PROG 2'h1
`define DPS_CTL_RF_REF 2'h2
`define DPS_CTL_RF_PROG 2'h3
`define DPS_REF_LSB 2
`define DPS_REF_W 14
`define DPS_REF_MIN 14'h0005
`define DPS_LOS_BIT 16
`define DPS_POL_BIT 17
`define DPS_SWAL_LSB 2
`define DPS_SWAL_W 7
`define DPS_PROG_LSB 9
`define DPS_PROG_W 11
`define DPS_PROG_MIN 11'h005
`define DPS_MOD_BIT 20
`define DPS_REF_RST 14'h0005
`define DPS_PROG_RST 11'h005
`endif

// file: dps_pkg.sv
// Purpose: Types for the dual synthesizer serial program port
// Assumes: Field widths follow dps_defines.svh
// Notes:   No constants live here, only types
package dps_pkg;
   typedef struct packed {
      logic [13:0] ref_count;
   } dps_ref_t;
   typedef struct packed {
      logic [10:0] prog_count;
      logic [6:0] swallow_count;
      logic high_modulus;
   } dps_main_t;
   typedef enum logic [2:0] {
      DPS_IDLE = 3'b001,
      DPS_LOAD = 3'b010,
      DPS_HOLD = 3'b100
   } dps_state_t;
endpackage : dps_pkg

// file: dps_sync.sv
// Purpose: Two flip-flop synchroniser for asynchronous pin inputs
// Assumes: Single clock i_sys_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module dps_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Data
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta;

   // Two stages to settle metastability
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         meta <= '0;
         o_sync <= '0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule : dps_sync

// file: dps_edge.sv
// Purpose: Rising edge finder on a synchronised level
// Assumes: Input already synchronised to i_sys_clk
// Notes:   Output is a one-cycle pulse
`timescale 1ns/1ps
module dps_edge (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Level in, pulse out
   input wire logic i_level,
   output logic o_rise
);
   logic last;

   // Remember previous level
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         last <= 1'b0;
      end else begin
         last <= i_level;
      end
   end

   assign o_rise = i_level & ~last;
endmodule : dps_edge

// file: dps_program_port.sv
// Purpose: Serial program port of a dual RF/IF frequency synthesizer
// Assumes: Serial clock, data, strobe and power-save pins are asynchronous
// Notes:   Pins pass two flops; one load per strobe high period
// Operation
// - 23-bit shift register, shift on clock rise
// - Strobe high copies word into chosen latch
// - Control bits pick one of four latches
// - Output select bit picks monitor or lock
// - IF power-save pin low saves power
// - RF power-save pin low, independent of IF
// - Polarity bit reverses phase detector sense
// - Reference divider 14 bits, range 5..16383
// - Main divider 18 bits, swallow plus programmable
// - Swallow counter 7 bits, 0..127
// - Programmable counter 11 bits, 5..2047
// - Prescaler 64/65 or 128/129 RF, 16/17 or 32/33 IF
// - Frequency M*N+A over R, A below N
`timescale 1ns/1ps
`include "dps_defines.svh"
module dps_program_port #(
   parameter int WORD_W = `DPS_WORD_W
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Serial program pins
   input wire logic i_serial_clk,
   input wire logic i_serial_data,
   input wire logic i_latch_load_strobe,
   // Power-save pins, active low
   input wire logic i_if_power_save_n,
   input wire logic i_rf_power_save_n,
   // Status from the analog loops
   input wire logic i_lock_detect,
   input wire logic i_phase_monitor,
   // Shared monitor pin
   output logic o_lock_detect_out,
   // Section enables
   output logic o_if_enable,
   output logic o_rf_enable,
   // Programmed settings
   output dps_pkg::dps_ref_t o_if_ref,
   output dps_pkg::dps_ref_t o_rf_ref,
   output dps_pkg::dps_main_t o_if_main,
   output dps_pkg::dps_main_t o_rf_main,
   output logic o_phase_polarity_select,
   output logic o_lock_output_select,
   // Prescaler moduli, low value of the pair
   output logic [7:0] o_rf_modulus,
   output logic [7:0] o_if_modulus,
   // Word refused for out-of-range divider value
   output logic o_word_error
);
   // Field positions are fixed, so refuse any other word width
   if (WORD_W != `DPS_WORD_W) begin : g_bad_width
      $error("WORD_W must equal the shift register width");
   end

   // Synchronised pins
   logic [4:0] pins_sync;
   logic sclk_s, sdat_s, strobe_s, if_ps_s, rf_ps_s;
   logic sclk_rise, strobe_rise;
   logic [WORD_W-1:0] shift;
   dps_pkg::dps_state_t state, next_state;
   logic [1:0] ctl;
   logic [13:0] word_ref;
   logic [6:0] word_swal;
   logic [10:0] word_prog;
   logic word_ok;
   logic monitor_sel, lock_sel;

   dps_sync #(.WIDTH(5)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_async({i_serial_clk, i_serial_data, i_latch_load_strobe,
                i_if_power_save_n, i_rf_power_save_n}),
      .o_sync(pins_sync)
   );
   assign {sclk_s, sdat_s, strobe_s, if_ps_s, rf_ps_s} = pins_sync;

   dps_edge u_sclk_edge (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_level(sclk_s),
      .o_rise(sclk_rise)
   );

   dps_edge u_strobe_edge (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_level(strobe_s),
      .o_rise(strobe_rise)
   );

   // Field extraction used by several latches
   function automatic logic [13:0] get_ref(input logic [WORD_W-1:0] w);
      get_ref = w[`DPS_REF_LSB +: `DPS_REF_W];
   endfunction : get_ref

   // Shift in one bit per serial clock rise while idle, MSB first
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         shift <= '0;
      end else if (sclk_rise && state == dps_pkg::DPS_IDLE) begin
         shift <= {shift[WORD_W-2:0], sdat_s};
      end
   end

   assign ctl = shift[`DPS_CTL_MSB:`DPS_CTL_LSB];
   assign word_ref = get_ref(shift);
   assign word_swal = shift[`DPS_SWAL_LSB +: `DPS_SWAL_W];
   assign word_prog = shift[`DPS_PROG_LSB +: `DPS_PROG_W];

   // Range checks; swallow must stay below programmable count
   always_comb begin
      word_ok = 1'b1;
      case (ctl)
         `DPS_CTL_IF_REF, `DPS_CTL_RF_REF: begin
            word_ok = (word_ref >= `DPS_REF_MIN);
         end
         default: begin
            word_ok = (word_prog >= `DPS_PROG_MIN) &&
               ({4'h0, word_swal} < word_prog);
         end
      endcase
   end

   // Load sequencer: one copy per strobe high period
   always_comb begin
      next_state = state;
      case (state)
         dps_pkg::DPS_IDLE: begin
            if (strobe_rise) begin
               next_state = dps_pkg::DPS_LOAD;
            end
         end
         dps_pkg::DPS_LOAD: begin
            next_state = dps_pkg::DPS_HOLD;
         end
         dps_pkg::DPS_HOLD: begin
            if (!strobe_s) begin
               next_state = dps_pkg::DPS_IDLE;
            end
         end
         default: begin
            next_state = dps_pkg::DPS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state <= dps_pkg::DPS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Latch write, at most one destination per word; refused words go nowhere
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_if_ref <= '{ref_count: `DPS_REF_RST};
         o_rf_ref <= '{ref_count: `DPS_REF_RST};
         o_if_main <= '{prog_count: `DPS_PROG_RST,
                        swallow_count: 7'h00, high_modulus: 1'b0};
         o_rf_main <= '{prog_count: `DPS_PROG_RST,
                        swallow_count: 7'h00, high_modulus: 1'b0};
         o_phase_polarity_select <= 1'b0;
         o_lock_output_select <= 1'b0;
         o_word_error <= 1'b0;
      end else if (state == dps_pkg::DPS_LOAD) begin
         o_word_error <= ~word_ok;
         if (word_ok) begin
            case (ctl)
               `DPS_CTL_IF_REF: begin
                  o_if_ref.ref_count <= word_ref;
                  o_lock_output_select <= shift[`DPS_LOS_BIT];
                  o_phase_polarity_select <= shift[`DPS_POL_BIT];
               end
               `DPS_CTL_RF_REF: begin
                  o_rf_ref.ref_count <= word_ref;
                  o_lock_output_select <= shift[`DPS_LOS_BIT];
                  o_phase_polarity_select <= shift[`DPS_POL_BIT];
               end
               `DPS_CTL_IF_PROG: begin
                  o_if_main <= '{prog_count: word_prog,
                                 swallow_count: word_swal,
                                 high_modulus: shift[`DPS_MOD_BIT]};
               end
               default: begin
                  o_rf_main <= '{prog_count: word_prog,
                                 swallow_count: word_swal,
                                 high_modulus: shift[`DPS_MOD_BIT]};
               end
            endcase
         end
      end
   end

   // Prescaler modulus from the pair selected per section
   assign o_rf_modulus = o_rf_main.high_modulus ? 8'h80 : 8'h40;
   assign o_if_modulus = o_if_main.high_modulus ? 8'h20 : 8'h10;

   // Power-save pins are levels; a floating pin is the board's fault
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_if_enable <= 1'b0;
         o_rf_enable <= 1'b0;
      end else begin
         o_if_enable <= if_ps_s;
         o_rf_enable <= rf_ps_s;
      end
   end

   // Shared pin mux, registered to keep the output glitch free
   assign monitor_sel = o_lock_output_select;
   assign lock_sel = ~o_lock_output_select;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_lock_detect_out <= 1'b0;
      end else begin
         o_lock_detect_out <= (monitor_sel & i_phase_monitor) |
            (lock_sel & i_lock_detect);
      end
   end

   // Checks
   a_load_once: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      state == dps_pkg::DPS_LOAD |=> state == dps_pkg::DPS_HOLD)
      else $error("load lasted more than one cycle");
   a_strobe_load: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      strobe_rise && state == dps_pkg::DPS_IDLE
      |=> state == dps_pkg::DPS_LOAD)
      else $error("strobe did not start a load");
   a_hold_strobe: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      state == dps_pkg::DPS_HOLD && strobe_s |=> state == dps_pkg::DPS_HOLD)
      else $error("second load inside one strobe period");
   a_shift_step: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      sclk_rise && state == dps_pkg::DPS_IDLE
      |=> shift[0] == $past(sdat_s) &&
          shift[WORD_W-1:1] == $past(shift[WORD_W-2:0]))
      else $error("shift register did not take the bit");
   a_if_ref_dest: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      state == dps_pkg::DPS_LOAD && word_ok && ctl == `DPS_CTL_IF_REF
      |=> o_if_ref.ref_count == $past(word_ref) && $stable(o_rf_ref)
          && $stable(o_if_main) && $stable(o_rf_main))
      else $error("IF reference load went astray");
   a_rf_ref_dest: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      state == dps_pkg::DPS_LOAD && word_ok && ctl == `DPS_CTL_RF_REF
      |=> o_rf_ref.ref_count == $past(word_ref) && $stable(o_if_ref)
          && $stable(o_if_main) && $stable(o_rf_main))
      else $error("RF reference load went astray");
   a_rf_main_dest: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      state == dps_pkg::DPS_LOAD && word_ok && ctl == `DPS_CTL_RF_PROG
      |=> o_rf_main.prog_count == $past(word_prog) &&
          o_rf_main.swallow_count == $past(word_swal) && $stable(o_if_main))
      else $error("RF main load went astray");
   a_if_main_dest: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      state == dps_pkg::DPS_LOAD && word_ok && ctl == `DPS_CTL_IF_PROG
      |=> o_if_main.swallow_count == $past(word_swal) &&
          o_if_main.prog_count == $past(word_prog) && $stable(o_rf_main))
      else $error("IF main load went astray");
   a_word_refused: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      state == dps_pkg::DPS_LOAD && !word_ok
      |=> o_word_error && $stable(o_if_ref) && $stable(o_rf_ref) &&
          $stable(o_if_main) && $stable(o_rf_main))
      else $error("refused word reached a latch");
   a_ref_range: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      o_if_ref.ref_count >= `DPS_REF_MIN && o_rf_ref.ref_count >= `DPS_REF_MIN)
      else $error("reference count below minimum");
   a_prog_range: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      o_rf_main.prog_count >= `DPS_PROG_MIN &&
      o_if_main.prog_count >= `DPS_PROG_MIN)
      else $error("programmable count below minimum");
   a_swal_below: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      {4'h0, o_rf_main.swallow_count} < o_rf_main.prog_count ||
      o_rf_main.swallow_count == 7'h00)
      else $error("swallow count not below programmable");
   a_monitor_mux: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      o_lock_output_select && $stable(o_lock_output_select)
      |=> o_lock_detect_out == $past(i_phase_monitor))
      else $error("monitor pin shows wrong source");
   a_lock_mux: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      !o_lock_output_select && $stable(o_lock_output_select)
      |=> o_lock_detect_out == $past(i_lock_detect))
      else $error("lock pin shows wrong source");
   a_if_power: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      !i_if_power_save_n [*3] |=> !o_if_enable)
      else $error("IF not saving power");
   a_if_power_on: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      i_if_power_save_n [*3] |=> o_if_enable)
      else $error("IF not running");
   a_rf_power: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      i_rf_power_save_n [*3] |=> o_rf_enable)
      else $error("RF not running");
   a_rf_power_off: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      !i_rf_power_save_n [*3] |=> !o_rf_enable)
      else $error("RF not saving power");
   a_rf_modulus: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      o_rf_modulus == (o_rf_main.high_modulus ? 8'h80 : 8'h40))
      else $error("RF modulus wrong");
   a_if_modulus: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      o_if_modulus == (o_if_main.high_modulus ? 8'h20 : 8'h10))
      else $error("IF modulus wrong");
endmodule : dps_program_port

// file: dps_host.sv
// Purpose: Controller model that programs the synthesizer serially
// Assumes: Serial pins are asynchronous to the device clock
// Notes:   Clock idles low, data shows the inverse of its last bit
`timescale 1ns/1ps
module dps_host (
   // Serial program pins toward the device
   output logic o_serial_clk,
   output logic o_serial_data,
   output logic o_latch_load_strobe
);
   // Idle levels from time zero
   initial begin
      o_serial_clk = 1'b0;
      o_serial_data = 1'b0;
      o_latch_load_strobe = 1'b0;
   end

   // Shift n bits MSB first at 48 ns, then pulse the strobe
   task automatic send(input logic [24:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         o_serial_data = w[i];
         #12 o_serial_clk = 1'b1;
         #24 o_serial_clk = 1'b0;
         #12;
      end
      // Strobe only after the last bit, held well over 2 cycles
      o_latch_load_strobe = 1'b1;
      #25 o_latch_load_strobe = 1'b0;
      // No pull on the data line, so leave it at the inverse of the last bit
      o_serial_data = ~w[0];
      #40;
   endtask : send
endmodule : dps_host

// file: dps_program_port_tb.sv
// Purpose: Self-checking bench for the serial program port
// Assumes: Word layout as shared with the device
// Notes:   Random legal words plus boundary and refused words
`timescale 1ns/1ps
module dps_program_port_tb;
   logic i_sys_clk, i_reset, i_serial_clk, i_serial_data;
   logic i_latch_load_strobe, i_if_power_save_n, i_rf_power_save_n;
   logic i_lock_detect, i_phase_monitor;
   logic o_lock_detect_out, o_if_enable, o_rf_enable;
   dps_pkg::dps_ref_t o_if_ref, o_rf_ref, e_if_ref, e_rf_ref;
   dps_pkg::dps_main_t o_if_main, o_rf_main, e_if_main, e_rf_main;
   logic o_phase_polarity_select, o_lock_output_select, o_word_error;
   logic [7:0] o_rf_modulus, o_if_modulus;
   logic e_pol, e_los, e_err;
   logic [31:0] r;
   int fails, n_tests, seed;

   dps_program_port dps_program_port_inst (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_serial_clk(i_serial_clk),
      .i_serial_data(i_serial_data),
      .i_latch_load_strobe(i_latch_load_strobe),
      .i_if_power_save_n(i_if_power_save_n),
      .i_rf_power_save_n(i_rf_power_save_n),
      .i_lock_detect(i_lock_detect),
      .i_phase_monitor(i_phase_monitor),
      .o_lock_detect_out(o_lock_detect_out),
      .o_if_enable(o_if_enable),
      .o_rf_enable(o_rf_enable),
      .o_if_ref(o_if_ref),
      .o_rf_ref(o_rf_ref),
      .o_if_main(o_if_main),
      .o_rf_main(o_rf_main),
      .o_phase_polarity_select(o_phase_polarity_select),
      .o_lock_output_select(o_lock_output_select),
      .o_rf_modulus(o_rf_modulus),
      .o_if_modulus(o_if_modulus),
      .o_word_error(o_word_error)
   );
   dps_host dps_host_inst (
      .o_serial_clk(i_serial_clk),
      .o_serial_data(i_serial_data),
      .o_latch_load_strobe(i_latch_load_strobe)
   );

   // 200 MHz system clock
   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic check(input string name, input logic [18:0] exp,
      input logic [18:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic check_all;
      check("if_ref", 19'(e_if_ref), 19'(o_if_ref));
      check("rf_ref", 19'(e_rf_ref), 19'(o_rf_ref));
      check("if_main", 19'(e_if_main), 19'(o_if_main));
      check("rf_main", 19'(e_rf_main), 19'(o_rf_main));
      check("polarity", 19'(e_pol), 19'(o_phase_polarity_select));
      check("out_sel", 19'(e_los), 19'(o_lock_output_select));
      check("word_err", 19'(e_err), 19'(o_word_error));
      check("rf_mod", e_rf_main.high_modulus ? 19'h80 : 19'h40,
         19'(o_rf_modulus));
      check("if_mod", e_if_main.high_modulus ? 19'h20 : 19'h10,
         19'(o_if_modulus));
   endtask : check_all

   function automatic logic [22:0] ref_w(input logic rf,
      input logic [13:0] c, input logic los, input logic pol);
      return {5'h00, pol, los, c, rf, 1'b0};
   endfunction : ref_w

   function automatic logic [22:0] main_w(input logic rf,
      input logic [10:0] p, input logic [6:0] s, input logic hm);
      return {2'h0, hm, p, s, rf, 1'b1};
   endfunction : main_w

   // Words the device must refuse: divider values out of range
   function automatic logic word_refused(input logic [22:0] w);
      if (!w[0]) begin
         return w[15:2] < 14'h0005;
      end
      return w[19:9] < 11'h005 || {4'h0, w[8:2]} >= w[19:9];
   endfunction : word_refused

   // Send a word, optionally behind junk bits, and predict the latches
   task automatic apply(input logic [22:0] w, input int extra);
      dps_host_inst.send({2'($random(seed)), w}, 23 + extra);
      e_err = word_refused(w);
      if (!w[0]) begin
         if (!e_err) begin
            e_rf_ref = w[1] ? w[15:2] : e_rf_ref;
            e_if_ref = w[1] ? e_if_ref : w[15:2];
            e_los = w[16];
            e_pol = w[17];
         end
      end else begin
         if (!e_err) begin
            e_rf_main = w[1] ? {w[19:9], w[8:2], w[20]} : e_rf_main;
            e_if_main = w[1] ? e_if_main : {w[19:9], w[8:2], w[20]};
         end
      end
      check_all();
   endtask : apply

   // Shared pin follows the selected source one cycle later
   task automatic mon_check;
      logic lk, pm;
      // Start just after an edge so the sources never race the clock
      @(posedge i_sys_clk);
      #1;
      repeat (10) begin
         lk = 1'($random(seed));
         pm = 1'($random(seed));
         i_lock_detect = lk;
         i_phase_monitor = pm;
         @(posedge i_sys_clk);
         #1;
         check("lock_pin", 19'(e_los ? pm : lk), 19'(o_lock_detect_out));
      end
   endtask : mon_check

   // Watchdog against a hung run
   initial begin
      repeat (100000) @(posedge i_sys_clk);
      fails++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      logic [10:0] p;
      seed = 32'h5969;
      fails = 0;
      n_tests = 0;
      i_reset = 1'b1;
      i_if_power_save_n = 1'b0;
      i_rf_power_save_n = 1'b0;
      i_lock_detect = 1'b0;
      i_phase_monitor = 1'b0;
      e_if_ref = 14'h0005;
      e_rf_ref = 14'h0005;
      e_if_main = {11'h005, 7'h00, 1'b0};
      e_rf_main = {11'h005, 7'h00, 1'b0};
      {e_pol, e_los, e_err} = 3'h0;
      repeat (2) @(posedge i_sys_clk);
      #1;
      i_reset = 1'b0;
      check_all();
      check("if_en", 19'h0, 19'(o_if_enable));
      check("rf_en", 19'h0, 19'(o_rf_enable));
      // Boundaries and refused words
      apply(ref_w(0, 14'h0005, 1, 1), 0);
      apply(ref_w(1, 14'h3FFF, 0, 0), 2);
      apply(ref_w(0, 14'h0004, 1, 0), 0);
      apply(main_w(0, 11'h7FF, 7'h7F, 1), 0);
      apply(main_w(1, 11'h005, 7'h04, 1), 2);
      apply(main_w(1, 11'h004, 7'h00, 0), 0);
      apply(main_w(0, 11'h00A, 7'h0A, 0), 0);
      // Random legal words to all four latches
      repeat (40) begin
         r = $random(seed);
         p = 11'($random(seed)) | 11'h005;
         if (r[0]) begin
            apply(main_w(r[1], p, r[8:2] >= p ? 7'(p - 1) : r[8:2], r[9]),
               r[10] ? 2 : 0);
         end else begin
            apply(ref_w(r[1], r[15:2] | 14'h0005, r[16], r[17]), 0);
         end
      end
      apply(ref_w(0, 14'h0064, 0, 0), 0);
      mon_check();
      apply(ref_w(1, 14'h00C8, 1, 1), 0);
      mon_check();
      // Power-save pins, each section on its own
      repeat (8) begin
         r = $random(seed);
         i_if_power_save_n = r[0];
         i_rf_power_save_n = r[1];
         repeat (4) @(posedge i_sys_clk);
         #1;
         check("if_en", 19'(r[0]), 19'(o_if_enable));
         check("rf_en", 19'(r[1]), 19'(o_rf_enable));
      end
      report_and_stop();
   end
endmodule : dps_program_port_tb
